// >>> src/smd_defines.svh
`ifndef SMD_DEFINES_SVH
`define SMD_DEFINES_SVH

// Operating mode codes
`define SMD_MODE_POS 2'h0
`define SMD_MODE_SPEED 2'h1
`define SMD_MODE_FLAG 2'h2

// Input bit positions inside the 6-bit input word (input n at bit n-1)
`define SMD_IN_START 0
`define SMD_IN_SEL_LO 1
`define SMD_IN_SEL_HI 4
`define SMD_IN_FLAG_SEL_HI 3
`define SMD_IN_TRIG 4
`define SMD_IN_SWITCH 5

// Output pair codes {output one, output two}
`define SMD_OUT_BUSY 2'h1
`define SMD_OUT_READY 2'h2
`define SMD_OUT_ERROR 2'h0
`define SMD_OUT_REF 2'h3

// Speed monitor threshold of lost full steps in one window
`define SMD_LOST_STEP_MAX 8'h19

`define SMD_IN_WIDTH 6
`define SMD_SYNC_ZERO 3'h0

`endif

// >>> src/smd_pkg.sv
package smd_pkg;

typedef enum logic [3:0] {
    SMD_ST_READY = 4'h1,
    SMD_ST_RUN = 4'h2,
    SMD_ST_FLAG_SPEED = 4'h4,
    SMD_ST_ERROR = 4'h8
} smd_state_e;

typedef struct packed {
    logic [1:0] mode;
    logic motionBusy;
    logic atReference;
    logic [7:0] lostSteps;
    logic overTemp;
} smd_core_s;

typedef struct packed {
    logic startPulse;
    logic trigPulse;
    logic runEnable;
    logic direction;
    logic [3:0] selIndex;
    logic limitSwitch;
    logic abortJob;
    logic errorClearPulse;
} smd_cmd_s;

endpackage

// >>> src/smd_io_decoder.sv
// What this block does
// - Position mode: start pulse on input one launches the selected profile
// - Falling edge on input one clears a pending speed-monitor error
// - Position mode: inputs two to five sampled when input one activates
// - Selection is binary, input two LSB; all off profile 1, all on 16
// - Position mode: input six is the limit or reference switch
// - Position outputs: busy off/on, ready on/off, error off/off, ref on/on
// - Speed mode: input one level enables running, low stops motor
// - Speed mode: input six selects rotation direction
// - Speed mode: inputs two to five read continuously, not latched
// - Speed changes follow the configured ramp, never jump
// - Speed outputs: run off/on, stopped on/off, error off/off, zero on/on
// - Flag mode: pulse on input one starts constant-speed phase
// - Flag mode: pulse on input five switches to positioning phase
// - Flag mode: inputs two to four sampled at start, eight profiles
// - Flag mode: input six is the limit or reference switch
// - Flag outputs: busy off/on, ready on/off, error off/off, ref on/on
// - Third output signals overtemperature
// - Flag profile runs at speed until trigger, then distance from trigger
// - Over 25 lost full steps in the window flags error and aborts job
`timescale 1ns/1ns
`include "smd_defines.svh"

module smd_io_decoder
(
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic [5:0] pinIn, // Optocoupled inputs one to six
    input wire smd_pkg::smd_core_s core, // Mode and motion core status
    output smd_pkg::smd_cmd_s cmd, // Commands towards the motion core
    output logic [1:0] statusPair, // {output one, output two}
    output logic overTempOut // Output three, overtemperature
);
    import smd_pkg::*;

    logic [2:0] sync_q [`SMD_IN_WIDTH];
    logic [5:0] filt_q;
    logic [5:0] filtPrev_q;
    logic [5:0] rise;
    logic [5:0] fall;
    smd_state_e state_q;
    logic error_q;
    logic startPulse_q;
    logic trigPulse_q;
    logic runEnable_q;
    logic direction_q;
    logic [3:0] selIndex_q;
    logic limitSwitch_q;
    logic abortJob_q;
    logic clearPulse_q;
    logic speedMode;
    logic flagMode;
    logic startEv;
    logic trigEv;
    logic clearEv;
    logic lostStepsOver;
    logic [3:0] selNow;

    // Three-stage sync per input; a new level counts once stages two and
    // three agree, so a single-cycle glitch never reaches the filter
    genvar gi;
    generate
        for (gi = 0; gi < `SMD_IN_WIDTH; gi++)
        begin : g_in
            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync_q[gi] <= `SMD_SYNC_ZERO;
                end
                else
                begin
                    sync_q[gi] <= {sync_q[gi][1:0], pinIn[gi]};
                end
            end

            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    filt_q[gi] <= 1'b0;
                end
                else if (sync_q[gi][1] == sync_q[gi][2])
                begin
                    filt_q[gi] <= sync_q[gi][2];
                end
            end
        end
    endgenerate

    // Previous filtered levels; reset matches the idle-low pins
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            filtPrev_q <= '0;
        end
        else
        begin
            filtPrev_q <= filt_q;
        end
    end

    assign rise = filt_q & ~filtPrev_q;
    assign fall = ~filt_q & filtPrev_q;
    assign speedMode = core.mode == `SMD_MODE_SPEED;
    assign flagMode = core.mode == `SMD_MODE_FLAG;
    assign startEv = rise[`SMD_IN_START] && !speedMode;
    assign trigEv = rise[`SMD_IN_TRIG] && flagMode;
    assign clearEv = fall[`SMD_IN_START];
    assign lostStepsOver = core.lostSteps > `SMD_LOST_STEP_MAX;

    // Selection index: binary, input two is the LSB, index 0 is profile one
    always_comb
    begin
        selNow = filt_q[`SMD_IN_SEL_HI:`SMD_IN_SEL_LO];
        if (flagMode)
        begin
            selNow = {1'b0,
                filt_q[`SMD_IN_FLAG_SEL_HI:`SMD_IN_SEL_LO]};
        end
    end

    // Speed-monitor error: set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            error_q <= 1'b0;
        end
        else if (lostStepsOver)
        begin
            error_q <= 1'b1;
        end
        else if (clearEv)
        begin
            error_q <= 1'b0;
        end
    end

    // Mode state; any speed-monitor error overrides the mode logic
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= SMD_ST_READY;
        end
        else if (error_q || lostStepsOver)
        begin
            state_q <= SMD_ST_ERROR;
        end
        else
        begin
            case (state_q)
                SMD_ST_READY:
                begin
                    if (speedMode && filt_q[`SMD_IN_START])
                    begin
                        state_q <= SMD_ST_RUN;
                    end
                    else if (startEv && flagMode)
                    begin
                        state_q <= SMD_ST_FLAG_SPEED;
                    end
                    else if (startEv)
                    begin
                        state_q <= SMD_ST_RUN;
                    end
                end
                SMD_ST_RUN:
                begin
                    if (speedMode)
                    begin
                        if (!filt_q[`SMD_IN_START])
                        begin
                            state_q <= SMD_ST_READY;
                        end
                    end
                    else if (!core.motionBusy && !startEv)
                    begin
                        state_q <= SMD_ST_READY;
                    end
                end
                SMD_ST_FLAG_SPEED:
                begin
                    // Constant speed until the trigger, then positioning
                    if (trigEv)
                    begin
                        state_q <= SMD_ST_RUN;
                    end
                end
                SMD_ST_ERROR:
                begin
                    // Error already cleared by a falling edge on input one
                    state_q <= SMD_ST_READY;
                end
                default:
                begin
                    state_q <= SMD_ST_READY;
                end
            endcase
        end
    end

    // Start pulse; refused in speed mode and while an error stands
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            startPulse_q <= 1'b0;
        else
            startPulse_q <= startEv && !error_q
                && !lostStepsOver;
    end

    // Trigger only counts during the constant-speed phase
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            trigPulse_q <= 1'b0;
        else
            trigPulse_q <= trigEv
                && state_q == SMD_ST_FLAG_SPEED;
    end

    // Level enable; the motion core ramps towards the selected speed
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            runEnable_q <= 1'b0;
        else
            runEnable_q <= speedMode && filt_q[`SMD_IN_START]
                && !error_q;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            direction_q <= 1'b0;
        else if (speedMode)
            direction_q <= filt_q[`SMD_IN_SWITCH];
    end

    // Followed continuously in speed mode, latched at start otherwise
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            selIndex_q <= '0;
        else if (speedMode)
            selIndex_q <= selNow;
        else if (startEv)
            selIndex_q <= selNow;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            limitSwitch_q <= 1'b0;
        else
            limitSwitch_q <= !speedMode
                && filt_q[`SMD_IN_SWITCH];
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            abortJob_q <= 1'b0;
        else
            abortJob_q <= lostStepsOver;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            clearPulse_q <= 1'b0;
        else
            clearPulse_q <= clearEv;
    end

    assign cmd = '{
        startPulse: startPulse_q,
        trigPulse: trigPulse_q,
        runEnable: runEnable_q,
        direction: direction_q,
        selIndex: selIndex_q,
        limitSwitch: limitSwitch_q,
        abortJob: abortJob_q,
        errorClearPulse: clearPulse_q
    };

    // Output pair, same layout in all three modes
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            statusPair <= `SMD_OUT_READY;
        end
        else if (state_q == SMD_ST_ERROR)
        begin
            statusPair <= `SMD_OUT_ERROR;
        end
        else if (state_q != SMD_ST_READY || core.motionBusy)
        begin
            statusPair <= `SMD_OUT_BUSY;
        end
        else if (core.atReference)
        begin
            statusPair <= `SMD_OUT_REF;
        end
        else
        begin
            statusPair <= `SMD_OUT_READY;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            overTempOut <= 1'b0;
        else
            overTempOut <= core.overTemp;
    end
endmodule

// >>> verif/smd_io_monitor.sv
`timescale 1ns/1ns
`include "smd_defines.svh"
module smd_io_monitor
(
    input wire logic clk_sys, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [5:0] pinIn, // Inputs
    input wire smd_pkg::smd_core_s core, // Core status
    input wire smd_pkg::smd_cmd_s cmd, // Commands
    input wire logic [1:0] statusPair, // Output pair
    input wire logic overTempOut // Output three
);
    import smd_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sequence spdSteady;
        (core.mode == `SMD_MODE_SPEED && $stable(pinIn)
            && statusPair != `SMD_OUT_ERROR)[*8];
    endsequence
    sequence errHeld;
        (core.lostSteps > `SMD_LOST_STEP_MAX)[*6];
    endsequence
    AST_RUN:
        assert property (spdSteady |-> cmd.runEnable == pinIn[0])
        else $error("run enable wrong");
    AST_DIR:
        assert property (spdSteady |-> cmd.direction == pinIn[5])
        else $error("direction wrong");
    AST_SEL:
        assert property (spdSteady |-> cmd.selIndex == pinIn[4:1])
        else $error("speed select wrong");
    AST_NOSTART:
        assert property ((core.mode == `SMD_MODE_SPEED)[*2]
            |-> !cmd.startPulse)
        else $error("start in speed mode");
    AST_PULSE:
        assert property (cmd.startPulse |=> !cmd.startPulse)
        else $error("start pulse too long");
    AST_ABORT:
        assert property (errHeld |-> cmd.abortJob)
        else $error("abort missing");
    AST_ERROUT:
        assert property (errHeld |-> statusPair == `SMD_OUT_ERROR)
        else $error("error pair missing");
    AST_TEMP:
        assert property ($stable(core.overTemp)
            |-> overTempOut == core.overTemp)
        else $error("overtemp output wrong");
endmodule

// >>> verif/smd_plc_model.sv
`timescale 1ns/1ns
module smd_plc_model
(
    input wire logic clk_sys, // Clock
    input wire logic [5:0] wantPins, // Levels asked for
    output logic [5:0] pinIn // Optocoupler inputs
);
    // Controller switches its outputs only at the falling edge
    initial pinIn = 6'h00;
    always @(negedge clk_sys) pinIn <= wantPins;
endmodule

// >>> verif/smd_io_decoder_bench.sv
`timescale 1ns/1ns
`include "smd_defines.svh"
module smd_io_decoder_bench;
    import smd_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] wantPins = 6'h00;
    logic [5:0] pinIn;
    smd_core_s core = '0;
    smd_cmd_s cmd;
    logic [1:0] statusPair;
    logic overTempOut;
    logic startSeen = 1'b0;
    logic trigSeen = 1'b0;
    logic clrSeen = 1'b0;
    logic [3:0] startSel = 4'h0;
    int n_errors = 0;
    int tests_run = 0;
    smd_plc_model plc_u (.clk_sys(clk_sys), .wantPins(wantPins),
        .pinIn(pinIn));
    smd_io_decoder dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pinIn(pinIn), .core(core), .cmd(cmd), .statusPair(statusPair),
        .overTempOut(overTempOut));
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (cmd.startPulse) startSeen = 1'b1;
        if (cmd.startPulse) startSel = cmd.selIndex;
        if (cmd.trigPulse) trigSeen = 1'b1;
        if (cmd.errorClearPulse) clrSeen = 1'b1;
    end
    task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pins(logic [5:0] v);
        wantPins = v;
        repeat (10) @(negedge clk_sys);
    endtask
    task automatic pos_mode();
        core.mode = `SMD_MODE_POS;
        pins(6'h1E);
        startSeen = 1'b0;
        pins(6'h1F);
        chk("start", 4'h1, {3'h0, startSeen});
        chk("profile", 4'hF, startSel);
        core.motionBusy = 1'b1;
        pins(6'h20);
        chk("busy", {2'h0, `SMD_OUT_BUSY}, {2'h0, statusPair});
        chk("switch", 4'h1, {3'h0, cmd.limitSwitch});
        chk("held", 4'hF, cmd.selIndex);
        core.motionBusy = 1'b0;
        core.atReference = 1'b1;
        pins(6'h00);
        chk("ref", {2'h0, `SMD_OUT_REF}, {2'h0, statusPair});
        core.atReference = 1'b0;
        pins(6'h00);
        chk("ready", {2'h0, `SMD_OUT_READY}, {2'h0, statusPair});
    endtask
    task automatic speed_mode();
        core.mode = `SMD_MODE_SPEED;
        startSeen = 1'b0;
        core.motionBusy = 1'b1;
        pins(6'h27);
        chk("run", 4'h1, {3'h0, cmd.runEnable});
        chk("dir", 4'h1, {3'h0, cmd.direction});
        chk("speed", 4'h3, cmd.selIndex);
        chk("nostart", 4'h0, {3'h0, startSeen});
        chk("running", {2'h0, `SMD_OUT_BUSY}, {2'h0, statusPair});
        pins(6'h19);
        chk("speed", 4'hC, cmd.selIndex);
        chk("dir", 4'h0, {3'h0, cmd.direction});
        clrSeen = 1'b0;
        core.motionBusy = 1'b0;
        pins(6'h18);
        chk("stop", 4'h0, {3'h0, cmd.runEnable});
        chk("clear", 4'h1, {3'h0, clrSeen});
        chk("stopped", {2'h0, `SMD_OUT_READY}, {2'h0, statusPair});
    endtask
    task automatic flag_mode();
        core.mode = `SMD_MODE_FLAG;
        pins(6'h0E);
        startSeen = 1'b0;
        trigSeen = 1'b0;
        pins(6'h0F);
        chk("fstart", 4'h1, {3'h0, startSeen});
        chk("fprofile", 4'h7, startSel);
        chk("fbusy", {2'h0, `SMD_OUT_BUSY}, {2'h0, statusPair});
        core.motionBusy = 1'b1;
        pins(6'h3E);
        chk("trigger", 4'h1, {3'h0, trigSeen});
        chk("fswitch", 4'h1, {3'h0, cmd.limitSwitch});
        core.motionBusy = 1'b0;
        pins(6'h00);
        chk("fready", {2'h0, `SMD_OUT_READY}, {2'h0, statusPair});
    endtask
    task automatic err_temp();
        core.mode = `SMD_MODE_POS;
        core.lostSteps = 8'h1A;
        pins(6'h00);
        chk("abort", 4'h1, {3'h0, cmd.abortJob});
        chk("err", {2'h0, `SMD_OUT_ERROR}, {2'h0, statusPair});
        core.lostSteps = 8'h19;
        startSeen = 1'b0;
        pins(6'h01);
        chk("abort", 4'h0, {3'h0, cmd.abortJob});
        chk("errstart", 4'h0, {3'h0, startSeen});
        chk("err", {2'h0, `SMD_OUT_ERROR}, {2'h0, statusPair});
        core.overTemp = 1'b1;
        pins(6'h00);
        chk("cleared", {2'h0, `SMD_OUT_READY}, {2'h0, statusPair});
        chk("temp", 4'h1, {3'h0, overTempOut});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        pos_mode();
        speed_mode();
        flag_mode();
        err_temp();
        end_sim();
    end
endmodule
bind smd_io_decoder smd_io_monitor mon_u (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .pinIn(pinIn), .core(core), .cmd(cmd),
    .statusPair(statusPair), .overTempOut(overTempOut));
